/* File: rtl/jicl_regs.svh */
// Register offsets, field positions, reset values and timing counts of the config loader
// What this block does
// - Jumperless mode fetches configuration from EEPROM after reset
// - Only the first EEPROM byte is configuration
// - Loaded byte bits 7:6 and 2:0 land in jumperless setting register
// - Load completes about 50 us after reset
// - Step register read increments I/O select, wrapping
// - Cleared unlock bit freezes I/O select on reads
// - Four interrupt pins, loaded byte picks one
// - Interrupt select changes only by reload, or to zero in jumper mode
// - Any soft reset port write while idle restarts like hardware reset
// - Soft reset keeps EEPROM control and data registers
// - Jumper mode: no load, pins address, first interrupt
// - Control bit 6 drives shift clock, bit 5 select
// - Data bit 7 reads EEPROM output, writes its input
// - Setting register bits 2:0 show I/O select outside jumper mode
`ifndef JICL_REGS_SVH
`define JICL_REGS_SVH

// Register offsets on the 5-bit system address
`define JICL_OFS_EE_CTRL 5'h10
`define JICL_OFS_EE_DATA 5'h11
`define JICL_OFS_IO_STEP 5'h12
`define JICL_OFS_JL_SET 5'h13
`define JICL_OFS_SOFT_RST 5'h18
`define JICL_SOFT_RST_MASK 5'h18

// Field positions
`define JICL_CTRL_SK_BIT 6
`define JICL_CTRL_CS_BIT 5
`define JICL_DATA_IO_BIT 7
`define JICL_CFG_IRQ_HI 7
`define JICL_CFG_IRQ_LO 6
`define JICL_CFG_IO_HI 2
`define JICL_CFG_IO_LO 0

// Reset values
`define JICL_RST_CFG 8'h00
`define JICL_RST_IO_SEL 3'h0
`define JICL_RST_IRQ_SEL 2'h0

// Serial read command: start bit then read opcode
`define JICL_EE_CMD_HEAD 3'h6
`define JICL_EE_ADDR_BITS 6

// Timing
`define JICL_CLK_PERIOD_NS 100
`define JICL_LOAD_TIME_US 50
`define JICL_LOAD_CYCLES ((`JICL_LOAD_TIME_US * 1000) / `JICL_CLK_PERIOD_NS)
`define JICL_SK_HALF_NS 1000
`define JICL_SK_HALF_CYCLES ((`JICL_SK_HALF_NS + `JICL_CLK_PERIOD_NS - 1) / `JICL_CLK_PERIOD_NS)

`endif

/* File: rtl/jicl_pkg.sv */
// Types shared by the config loader
package jicl_pkg;
    typedef enum logic [2:0] {
        LD_OFF,
        LD_SELECT,
        LD_SHIFT_CMD,
        LD_SHIFT_DATA,
        LD_DESELECT,
        LD_HOLD
    } jicl_load_state_t;
endpackage

/* File: rtl/jicl_tick_div.sv */
// Divider that makes the one-cycle shift-clock half-period enable
`timescale 1ns/1ns
module jicl_tick_div #(
    parameter int HALF_CYCLES = 10
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Control
    input wire logic clear_i,
    output logic tick_o
);
    localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire at_last = (cnt_q == LAST);

    if (HALF_CYCLES < 1) begin : g_chk
        $error("jicl_tick_div: HALF_CYCLES must be at least 1");
    end

    assign cnt_d = (clear_i || at_last) ? '0 : cnt_q + CW'(1);
    assign tick_o = at_last && !clear_i;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

/* File: rtl/jicl_loader.sv */
// Jumperless ISA configuration loader with EEPROM port, I/O base stepping and soft reset ports
`timescale 1ns/1ns
`include "jicl_regs.svh"
module jicl_loader #(
    parameter int ADDR_BITS = `JICL_EE_ADDR_BITS,
    parameter int CFG_BITS = 8,
    parameter int LOAD_CYCLES = `JICL_LOAD_CYCLES,
    parameter int SK_HALF_CYCLES = `JICL_SK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Mode and straps
    input wire logic jumper_mode_i,
    input wire logic [2:0] jumper_io_sel_i,
    input wire logic io_base_unlock_i,
    // Interrupts
    input wire logic irq_req_i,
    output logic [3:0] irq_out_o,
    // Host decode and status
    output logic [2:0] io_window_select_o,
    output logic io_decode_en_o,
    output logic config_busy_o,
    output logic soft_reset_o,
    // Serial EEPROM
    output logic eeprom_chip_select_o,
    output logic eeprom_shift_clock_o,
    output logic eeprom_serial_io_o,
    input wire logic eeprom_serial_io_i
);
    localparam int CMD_BITS = 3 + ADDR_BITS;
    localparam int TW = $clog2(LOAD_CYCLES + 1);
    localparam int BW = $clog2(CMD_BITS + CFG_BITS + 1);
    localparam logic [TW-1:0] LOAD_LAST = TW'(LOAD_CYCLES - 1);
    localparam logic [BW-1:0] CMD_LAST = BW'(CMD_BITS - 1);
    localparam logic [BW-1:0] CFG_LAST = BW'(CFG_BITS - 1);
    localparam logic [CMD_BITS-1:0] CMD_WORD = {`JICL_EE_CMD_HEAD, {ADDR_BITS{1'b0}}};

    if (CFG_BITS != 8) begin : g_chk_cfg
        $error("jicl_loader: CFG_BITS must be 8");
    end
    if (ADDR_BITS < 6 || ADDR_BITS > 8) begin : g_chk_addr
        $error("jicl_loader: ADDR_BITS must be 6 to 8");
    end
    if (2 * SK_HALF_CYCLES * (CMD_BITS + CFG_BITS + 2) > LOAD_CYCLES) begin : g_chk_time
        $error("jicl_loader: serial read does not fit in LOAD_CYCLES");
    end

    function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    function automatic logic [3:0] irq_route(input logic req, input logic [1:0] sel);
        irq_route = req ? (4'h1 << sel) : 4'h0;
    endfunction

    // State
    jicl_pkg::jicl_load_state_t state_q;
    jicl_pkg::jicl_load_state_t state_d;
    logic [TW-1:0] timer_q;
    logic [TW-1:0] timer_d;
    logic [BW-1:0] bit_q;
    logic [BW-1:0] bit_d;
    logic [CMD_BITS-1:0] cmd_q;
    logic [CMD_BITS-1:0] cmd_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic ld_cs_q;
    logic ld_cs_d;
    logic ld_sk_q;
    logic ld_sk_d;
    logic ld_di_q;
    logic ld_di_d;
    logic [2:0] io_sel_q;
    logic [2:0] io_sel_d;
    logic [1:0] irq_sel_q;
    logic [1:0] irq_sel_d;
    logic sw_sk_q;
    logic sw_cs_q;
    logic sw_di_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [3:0] irq_out_q;
    logic soft_q;
    logic tick;

    // Decode; host access is refused while loading
    wire busy = (state_q != jicl_pkg::LD_OFF);
    wire host_ok = !busy;
    wire wr_ok = reg_wr_i && host_ok;
    wire rd_ok = reg_rd_i && host_ok;
    wire hit_ctrl = reg_hit(reg_addr_i, `JICL_OFS_EE_CTRL);
    wire hit_data = reg_hit(reg_addr_i, `JICL_OFS_EE_DATA);
    wire hit_step = reg_hit(reg_addr_i, `JICL_OFS_IO_STEP);
    wire hit_set = reg_hit(reg_addr_i, `JICL_OFS_JL_SET);
    wire hit_rst = reg_hit(reg_addr_i & `JICL_SOFT_RST_MASK, `JICL_OFS_SOFT_RST);
    wire soft_hit = wr_ok && hit_rst;
    wire step_hit = rd_ok && hit_step;
    wire step_go = step_hit && !jumper_mode_i && io_base_unlock_i;
    wire restart = reset_i || soft_hit;
    wire loading = (state_q != jicl_pkg::LD_OFF) && (state_q != jicl_pkg::LD_HOLD);
    wire sk_fall = tick && ld_sk_q;
    wire sk_rise = tick && !ld_sk_q;
    wire timer_end = (timer_q == LOAD_LAST);

    jicl_tick_div #(
        .HALF_CYCLES(SK_HALF_CYCLES)
    ) u_tick (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .clear_i(!loading),
        .tick_o(tick)
    );

    // Load sequencer: start bit, read opcode, address zero, then one byte
    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        cmd_d = cmd_q;
        shift_d = shift_q;
        ld_cs_d = ld_cs_q;
        ld_sk_d = ld_sk_q;
        ld_di_d = ld_di_q;
        timer_d = busy ? timer_q + TW'(1) : '0;
        unique case (state_q)
            jicl_pkg::LD_OFF: begin
            end
            jicl_pkg::LD_SELECT: begin
                if (jumper_mode_i) begin
                    state_d = jicl_pkg::LD_OFF;
                end else if (tick) begin
                    ld_cs_d = 1'b1;
                    ld_di_d = CMD_WORD[CMD_BITS-1];
                    cmd_d = CMD_WORD << 1;
                    bit_d = '0;
                    state_d = jicl_pkg::LD_SHIFT_CMD;
                end
            end
            jicl_pkg::LD_SHIFT_CMD: begin
                if (sk_rise) begin
                    ld_sk_d = 1'b1;
                end else if (sk_fall) begin
                    ld_sk_d = 1'b0;
                    ld_di_d = cmd_q[CMD_BITS-1];
                    cmd_d = cmd_q << 1;
                    if (bit_q == CMD_LAST) begin
                        ld_di_d = 1'b0;
                        bit_d = '0;
                        state_d = jicl_pkg::LD_SHIFT_DATA;
                    end else begin
                        bit_d = bit_q + BW'(1);
                    end
                end
            end
            jicl_pkg::LD_SHIFT_DATA: begin
                if (sk_rise) begin
                    ld_sk_d = 1'b1;
                end else if (sk_fall) begin
                    ld_sk_d = 1'b0;
                    shift_d = {shift_q[6:0], eeprom_serial_io_i};
                    if (bit_q == CFG_LAST) begin
                        state_d = jicl_pkg::LD_DESELECT;
                    end else begin
                        bit_d = bit_q + BW'(1);
                    end
                end
            end
            jicl_pkg::LD_DESELECT: begin
                ld_cs_d = 1'b0;
                state_d = jicl_pkg::LD_HOLD;
            end
            jicl_pkg::LD_HOLD: begin
                if (timer_end) begin
                    state_d = jicl_pkg::LD_OFF;
                end
            end
        endcase
    end

    // Configuration fields
    assign io_sel_d = jumper_mode_i ? jumper_io_sel_i :
                      (state_q == jicl_pkg::LD_DESELECT) ? shift_q[`JICL_CFG_IO_HI:`JICL_CFG_IO_LO] :
                      step_go ? io_sel_q + 3'h1 : io_sel_q;
    // Interrupt select only moves on restart, when a fresh byte arrives, or to zero in jumper mode
    assign irq_sel_d = jumper_mode_i ? 2'h0 :
                       (state_q == jicl_pkg::LD_DESELECT) ? shift_q[`JICL_CFG_IRQ_HI:`JICL_CFG_IRQ_LO] :
                       irq_sel_q;

    // Read data, standing one cycle after the strobe
    wire [7:0] set_view = {irq_sel_q, 3'h0, io_sel_q};
    wire [7:0] ctrl_view = {1'b0, sw_sk_q, sw_cs_q, 5'h00};
    wire [7:0] data_view = {eeprom_serial_io_i, 7'h00};
    assign rdata_d = !rd_ok ? 8'h00 :
                     hit_set ? (jumper_mode_i ? 8'h00 : set_view) :
                     hit_ctrl ? ctrl_view :
                     hit_data ? data_view : 8'h00;

    always_ff @(posedge core_clk_i) begin
        if (restart) begin
            state_q <= jicl_pkg::LD_SELECT;
            timer_q <= '0;
            bit_q <= '0;
            cmd_q <= '0;
            shift_q <= `JICL_RST_CFG;
            ld_cs_q <= 1'b0;
            ld_sk_q <= 1'b0;
            ld_di_q <= 1'b0;
            io_sel_q <= `JICL_RST_IO_SEL;
            irq_sel_q <= `JICL_RST_IRQ_SEL;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            bit_q <= bit_d;
            cmd_q <= cmd_d;
            shift_q <= shift_d;
            ld_cs_q <= ld_cs_d;
            ld_sk_q <= ld_sk_d;
            ld_di_q <= ld_di_d;
            io_sel_q <= io_sel_d;
            irq_sel_q <= irq_sel_d;
        end
    end

    // Software EEPROM pins survive a soft reset
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sw_sk_q <= 1'b0;
            sw_cs_q <= 1'b0;
            sw_di_q <= 1'b0;
        end else begin
            if (wr_ok && hit_ctrl) begin
                sw_sk_q <= reg_wdata_i[`JICL_CTRL_SK_BIT];
                sw_cs_q <= reg_wdata_i[`JICL_CTRL_CS_BIT];
            end
            if (wr_ok && hit_data) begin
                sw_di_q <= reg_wdata_i[`JICL_DATA_IO_BIT];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_q <= 8'h00;
            irq_out_q <= 4'h0;
            soft_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            // Quiet on the soft reset edge too, so no pin pulses as the reload begins
            irq_out_q <= (busy || soft_hit) ? 4'h0 : irq_route(irq_req_i, irq_sel_q);
            soft_q <= soft_hit;
        end
    end

    // Loader owns the pins only while it runs, then hands them back
    assign eeprom_chip_select_o = loading ? ld_cs_q : sw_cs_q;
    assign eeprom_shift_clock_o = loading ? ld_sk_q : sw_sk_q;
    assign eeprom_serial_io_o = loading ? ld_di_q : sw_di_q;
    assign reg_rdata_o = rdata_q;
    assign irq_out_o = irq_out_q;
    assign io_window_select_o = io_sel_q;
    assign io_decode_en_o = !busy;
    assign config_busy_o = busy;
    assign soft_reset_o = soft_q;

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    logic [TW-1:0] busy_len_q;
    always_ff @(posedge core_clk_i) begin
        if (restart) begin
            busy_len_q <= '0;
        end else if (busy) begin
            busy_len_q <= busy_len_q + TW'(1);
        end
    end

    decode_hold_a: assert property (config_busy_o |-> !io_decode_en_o && irq_out_o == 4'h0)
        else $error("decode or interrupt active during load");
    load_time_a: assert property ($fell(config_busy_o) && !$past(jumper_mode_i) |-> $past(busy_len_q) == LOAD_LAST)
        else $error("load did not end at the load time");
    cfg_capture_a: assert property (state_q == jicl_pkg::LD_DESELECT && !jumper_mode_i
        |=> io_sel_q == $past(shift_q[2:0]) && irq_sel_q == $past(shift_q[7:6]))
        else $error("configuration byte not captured");
    step_inc_a: assert property (step_go && !soft_hit |=> io_sel_q == $past(io_sel_q) + 3'h1)
        else $error("step read did not advance the I/O select");
    step_lock_a: assert property (step_hit && !io_base_unlock_i && !jumper_mode_i |=> $stable(io_sel_q))
        else $error("locked step read changed the I/O select");
    irq_route_a: assert property (!config_busy_o && !jumper_mode_i ##1 !config_busy_o
        |-> irq_out_o == irq_route($past(irq_req_i), $past(irq_sel_q)))
        else $error("interrupt not routed to the selected pin");
    irq_fixed_a: assert property (!config_busy_o && !jumper_mode_i && !soft_hit |=> $stable(irq_sel_q))
        else $error("interrupt select moved without a reload");
    soft_restart_a: assert property (soft_hit |=> config_busy_o && soft_reset_o && state_q == jicl_pkg::LD_SELECT)
        else $error("soft reset port write did not restart");
    soft_keep_a: assert property (soft_hit |=> $stable(sw_cs_q) && $stable(sw_sk_q) && $stable(sw_di_q))
        else $error("soft reset disturbed the EEPROM registers");
    jumper_first_a: assert property (jumper_mode_i && !config_busy_o |=> irq_out_o[3:1] == 3'h0)
        else $error("jumper mode used a pin other than the first");
    cs_release_a: assert property (state_q == jicl_pkg::LD_DESELECT |=> eeprom_chip_select_o == sw_cs_q)
        else $error("loader did not release the EEPROM pins");

    load_done_c: cover property ($fell(config_busy_o) && !jumper_mode_i);
    step_seen_c: cover property (step_go ##2 step_go);
    soft_seen_c: cover property (soft_hit ##[1:600] $fell(config_busy_o));
endmodule

/* File: test/jicl_eeprom_model.sv */
// Behavioural three-wire serial EEPROM holding the configuration byte
`timescale 1ns/1ns
module jicl_eeprom_model (
    // Serial pins
    input wire logic cs_i,
    input wire logic sk_i,
    input wire logic di_i,
    output logic do_o,
    // Content and status
    input wire logic [7:0] cfg_byte_i,
    output logic cmd_err_o
);
    int n_bits;
    logic [8:0] cmd;

    initial begin
        do_o = 1'b0;
        cmd_err_o = 1'b0;
        n_bits = 0;
        cmd = 9'h000;
    end

    // A new frame starts at chip select; old command bits are dropped
    always @(posedge cs_i) begin
        n_bits = 0;
        cmd_err_o = 1'b0;
    end

    // Command is start bit, read opcode and address zero
    // Only byte zero is held: the loader must stop after eight data bits
    always @(posedge sk_i) begin
        if (cs_i) begin
            if (n_bits < 9) begin
                cmd = {cmd[7:0], di_i};
                if (n_bits == 8 && cmd != 9'h180) begin
                    cmd_err_o = 1'b1;
                end
            end else if (n_bits < 17) begin
                do_o = cfg_byte_i[16 - n_bits];
            end
            n_bits++;
        end
    end

    // Released line has no pull: show the inverse so stale data is never read as valid
    always @(negedge cs_i) begin
        do_o = ~do_o;
    end
endmodule

/* File: test/jumperless_isa_config_loader_tb_top.sv */
// Testbench for the jumperless configuration loader
`timescale 1ns/1ns
`include "jicl_regs.svh"
module jumperless_isa_config_loader_tb_top;
    localparam int LOAD = 60;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [4:0] reg_addr_i = 5'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic jumper_mode_i = 1'b0;
    logic [2:0] jumper_io_sel_i = 3'h0;
    logic io_base_unlock_i = 1'b1;
    logic irq_req_i = 1'b1;
    logic [7:0] reg_rdata_o;
    logic [3:0] irq_out_o;
    logic [2:0] io_window_select_o;
    logic io_decode_en_o, config_busy_o, soft_reset_o;
    logic cs, sk, di, ee_do, ee_err;
    logic [7:0] ee_byte = 8'h85;
    logic [7:0] rd_q;
    int n;
    int n_fail = 0;
    int cmp_count = 0;

    always #50 core_clk_i = ~core_clk_i;

    // Short load keeps the run brief; one-cycle shift half period
    jicl_loader #(.LOAD_CYCLES(LOAD), .SK_HALF_CYCLES(1)) u_jicl_loader (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .jumper_mode_i(jumper_mode_i), .jumper_io_sel_i(jumper_io_sel_i),
        .io_base_unlock_i(io_base_unlock_i), .irq_req_i(irq_req_i), .irq_out_o(irq_out_o),
        .io_window_select_o(io_window_select_o), .io_decode_en_o(io_decode_en_o),
        .config_busy_o(config_busy_o), .soft_reset_o(soft_reset_o),
        .eeprom_chip_select_o(cs), .eeprom_shift_clock_o(sk), .eeprom_serial_io_o(di),
        .eeprom_serial_io_i(ee_do)
    );

    jicl_eeprom_model u_jicl_eeprom_model (
        .cs_i(cs), .sk_i(sk), .di_i(di), .do_o(ee_do), .cfg_byte_i(ee_byte), .cmd_err_o(ee_err)
    );

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Each access drives on a rising edge, drops the strobe at the next rising edge and returns at the falling edge after it, where results are settled
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(negedge core_clk_i);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        d = reg_rdata_o;
    endtask

    // Bounded wait for the end of a load, probing outputs on the twentieth cycle
    task automatic wait_idle();
        n = 0;
        do begin
            @(posedge core_clk_i);
            @(negedge core_clk_i);
            n++;
            if (n == 20) begin
                check("irq during load", 8'h00, {4'h0, irq_out_o});
                check("decode during load", 8'h00, {7'h0, io_decode_en_o});
            end
        end while (config_busy_o !== 1'b0 && n < 1000);
    endtask

    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (16) @(posedge core_clk_i);
        reset_i <= 1'b0;
        wait_idle();
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        check("load time", 8'h01, {7'h0, n >= LOAD && n <= LOAD + 2});
        check("command bits", 8'h00, {7'h0, ee_err});
        check("select released", 8'h00, {7'h0, cs});
        check("decode enabled", 8'h01, {7'h0, io_decode_en_o});
        rd(`JICL_OFS_JL_SET, rd_q);
        check("setting", 8'h85, rd_q);
        check("io window", 8'h05, {5'h0, io_window_select_o});
        check("irq pins", 8'h04, {4'h0, irq_out_o});
        // Host probing: step three times, crossing the wrap
        for (int i = 0; i < 3; i++) begin
            rd(`JICL_OFS_IO_STEP, rd_q);
        end
        rd(`JICL_OFS_JL_SET, rd_q);
        check("after steps", 8'h80, rd_q);
        @(posedge core_clk_i);
        io_base_unlock_i <= 1'b0;
        rd(`JICL_OFS_IO_STEP, rd_q);
        rd(`JICL_OFS_JL_SET, rd_q);
        check("locked step", 8'h80, rd_q);
        rd(5'h14, rd_q);
        check("unmapped read", 8'h00, rd_q);
        // Soft reset with new EEPROM content; software shift clock bit must survive
        wr(`JICL_OFS_EE_CTRL, 8'h40);
        ee_byte = 8'h4A;
        wr(5'h1F, 8'h5A);
        check("soft reset pulse", 8'h01, {7'h0, soft_reset_o});
        wait_idle();
        check("reload command", 8'h00, {7'h0, ee_err});
        rd(`JICL_OFS_JL_SET, rd_q);
        check("reloaded setting", 8'h42, rd_q);
        check("new irq pin", 8'h02, {4'h0, irq_out_o});
        // A dropped request must leave the selected pin quiet one cycle later
        @(posedge core_clk_i);
        irq_req_i <= 1'b0;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        check("irq follows request", 8'h00, {4'h0, irq_out_o});
        @(posedge core_clk_i);
        irq_req_i <= 1'b1;
        rd(`JICL_OFS_EE_CTRL, rd_q);
        check("ctrl kept", 8'h40, rd_q);
        // Jumper mode: pins give the window, first irq pin, no load
        @(posedge core_clk_i);
        jumper_mode_i <= 1'b1;
        jumper_io_sel_i <= 3'h6;
        io_base_unlock_i <= 1'b1;
        do_reset();
        check("jumper window", 8'h06, {5'h0, io_window_select_o});
        rd(`JICL_OFS_IO_STEP, rd_q);
        check("jumper step", 8'h06, {5'h0, io_window_select_o});
        // Pins follow one cycle after the short jumper-mode load ends
        check("jumper irq", 8'h01, {4'h0, irq_out_o});
        rd(`JICL_OFS_EE_CTRL, rd_q);
        check("ctrl cleared", 8'h00, rd_q);
        wr(`JICL_OFS_EE_CTRL, 8'h60);
        check("sk and cs pins", 8'h03, {6'h0, sk, cs});
        rd(`JICL_OFS_EE_CTRL, rd_q);
        check("ctrl readback", 8'h60, rd_q);
        wr(`JICL_OFS_EE_DATA, 8'h80);
        check("data in pin", 8'h01, {7'h0, di});
        rd(`JICL_OFS_EE_DATA, rd_q);
        check("data out bit", {ee_do, 7'h00}, rd_q);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_fail++;
        report_and_stop();
    end
endmodule
